// [sim/ics_host_model.sv]
// apb master standing in for the host processor that reads and clears causes.
// assumes one clock and a slave that raises pready for one cycle per access.
module ics_host_model (
  input wire logic pclk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  ////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one transfer: setup, then access until pready is seen at an edge
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wdata,
                      output logic [31:0] rdata, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    // no wait count assumed: the bench timeout ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // released lines show the inverse, so a stale value never looks valid
    paddr <= ~addr;
    pwdata <= ~wdata;
  endtask
endmodule // ics_host_model

// [sim/testbench.sv]
// self-checking bench of the interrupt cause block, host model on apb.
// assumes the design answers every apb access and registers its pins.
`include "ics_cfg.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0; // 200 mhz
  logic presetn = 1'b0;
  logic [15:0] pulse_vec = 16'h0000; // event pulses at their cause bit positions, ten of the sixteen bits used
  logic [6:0] station_time = 7'h00;
  logic station_time_stb = 1'b0;
  logic [15:0] block_dirty = 16'h0000;
  logic group_cmp_stb = 1'b0;
  logic [63:0] expected_group_set = 64'h0000_0000_0000_0000;
  logic [63:0] present_member_set = 64'h0000_0000_0000_0000;
  logic run_phase = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic irq_pin_a_n, irq_pin_b_n, irq_pin_c_n, status_freeze;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;
  int evs[10] = '{2, 3, 6, 7, 10, 11, 12, 13, 14, 15};

  always #2.5 pclk = ~pclk;

  ics_host_model u_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  ics_irq_cause u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .station_time(station_time), .station_time_stb(station_time_stb), .block_dirty(block_dirty),
    .mail_in_done(pulse_vec[2]), .mail_out_done(pulse_vec[3]), .group_cmp_stb(group_cmp_stb),
    .expected_group_set(expected_group_set), .present_member_set(present_member_set),
    .resize_done(pulse_vec[6]), .net_halt(pulse_vec[7]), .run_phase(run_phase),
    .link_good_stb(pulse_vec[10]), .link_bad_stb(pulse_vec[11]), .break_rx(pulse_vec[12]),
    .resize_clash(pulse_vec[13]), .echo_rx(pulse_vec[14]), .jam_rx(pulse_vec[15]),
    .irq_pin_a_n(irq_pin_a_n), .irq_pin_b_n(irq_pin_b_n), .irq_pin_c_n(irq_pin_c_n),
    .status_freeze(status_freeze));

  ////////////////////////////////////////////////////////////////////////////
  // verdict and end of run, reached from the main sequence or the timeout
  task automatic results();
    $display("comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // a hang is cut short well above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] dt);
    logic [31:0] d;
    logic e;
    u_host.xfer(1'b1, a, dt, d, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    logic [31:0] d;
    logic e;
    u_host.xfer(1'b0, a, 32'h0000_0000, d, e);
    chk(nm, exp, d);
  endtask

  // pins as one word: a in bit 0, b in bit 1, c in bit 2
  function automatic logic [31:0] pins();
    return {29'h0, irq_pin_c_n, irq_pin_b_n, irq_pin_a_n};
  endfunction

  task automatic pulse(input int b);
    @(posedge pclk);
    pulse_vec <= 16'h0001 << b;
    @(posedge pclk);
    pulse_vec <= 16'h0000;
    #1;
  endtask

  task automatic clr_all();
    wr(`ICS_OFF_CAUSE_A, 32'h0000_FFFF);
    wr(`ICS_OFF_CAUSE_B, 32'h0000_FFFF);
    wr(`ICS_OFF_CAUSE_C, 32'h0000_FFFF);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // reset values, unmapped access, enable protection and masks
  task automatic t_regs();
    logic [31:0] d;
    logic e;
    for (int i = 0; i < 9; i++) rd_chk(12'(i * 4), 32'h0000_0000, "reset value");
    u_host.xfer(1'b0, 12'h100, 32'h0000_0000, d, e);
    chk("unmapped error", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, d);
    wr(`ICS_OFF_ENABLE_A, 32'h0000_FFFF);
    wr(`ICS_OFF_ENABLE_B, 32'h0000_FFFF);
    rd_chk(`ICS_OFF_ENABLE_B, 32'h0000_FFFD, "enable b");
    wr(`ICS_OFF_ENABLE_C, 32'h0000_FFFF);
    rd_chk(`ICS_OFF_ENABLE_C, 32'h0000_FFFC, "enable c");
    wr(`ICS_OFF_TIMING_B, 32'h0000_8007);
    rd_chk(`ICS_OFF_TIMING_B, 32'h0000_0007, "timing b");
  endtask

  // every single-pulse cause on all three pins, then cleared
  task automatic t_events();
    foreach (evs[i]) begin
      pulse(evs[i]);
      chk("pins low", 32'h0000_0000, pins());
      chk("freeze", {31'h0, evs[i] == 10 || evs[i] == 11}, {31'h0, status_freeze});
      rd_chk(`ICS_OFF_CAUSE_A, 32'h1 << evs[i], "cause a");
      rd_chk(`ICS_OFF_CAUSE_B, 32'h1 << evs[i], "cause b");
      rd_chk(`ICS_OFF_CAUSE_C, 32'h1 << evs[i], "cause c");
      clr_all();
      chk("pins high", 32'h0000_0007, pins());
      rd_chk(`ICS_OFF_CAUSE_A, 32'h0000_0000, "cleared a");
    end
  endtask

  // membership count, group compare both ways, run phase entry
  task automatic t_group();
    @(posedge pclk);
    present_member_set <= 64'h3;
    expected_group_set <= 64'h1;
    group_cmp_stb <= 1'b1;
    @(posedge pclk);
    group_cmp_stb <= 1'b0;
    #1;
    chk("freeze member", 32'h0000_0001, {31'h0, status_freeze});
    rd_chk(`ICS_OFF_CAUSE_A, 32'h0000_0210, "cause smaller");
    clr_all();
    @(posedge pclk);
    expected_group_set <= 64'hF;
    group_cmp_stb <= 1'b1;
    run_phase <= 1'b1;
    @(posedge pclk);
    group_cmp_stb <= 1'b0;
    rd_chk(`ICS_OFF_CAUSE_A, 32'h0000_0130, "cause greater");
    clr_all();
  endtask

  // alarm and renewal times per pin, pin c without them
  task automatic t_timing();
    wr(`ICS_OFF_TIMING_A, 32'h0000_0A05);
    wr(`ICS_OFF_TIMING_B, 32'h0000_0C07);
    wr(`ICS_OFF_WATCH, 32'h0000_0001);
    for (int t = 5; t <= 12; t++) begin
      @(posedge pclk);
      station_time <= 7'(t);
      station_time_stb <= (t == 5 || t == 7 || t == 10 || t == 12);
      block_dirty <= (t == 10 || t == 12) ? 16'h0001 : 16'h0000;
    end
    @(posedge pclk);
    station_time_stb <= 1'b0;
    block_dirty <= 16'h0000;
    rd_chk(`ICS_OFF_CAUSE_A, 32'h0000_0003, "alarm a");
    rd_chk(`ICS_OFF_CAUSE_B, 32'h0000_0003, "alarm b");
    rd_chk(`ICS_OFF_CAUSE_C, 32'h0000_0000, "alarm c");
    clr_all();
  endtask

  // enable gating, zero writes ignored, event beats simultaneous clear
  task automatic t_clear();
    wr(`ICS_OFF_ENABLE_A, 32'h0000_0000);
    pulse(2);
    chk("pin a disabled", 32'h0000_0001, {31'h0, irq_pin_a_n});
    wr(`ICS_OFF_CAUSE_A, 32'h0000_0000);
    rd_chk(`ICS_OFF_CAUSE_A, 32'h0000_0004, "zero write");
    wr(`ICS_OFF_ENABLE_A, 32'h0000_FFFF);
    #1;
    chk("pin a enabled", 32'h0000_0000, {31'h0, irq_pin_a_n});
    fork
      wr(`ICS_OFF_CAUSE_A, 32'h0000_0004);
      begin
        do @(posedge pclk); while (!(psel === 1'b1 && penable === 1'b0));
        pulse_vec <= 16'h0004;
        @(posedge pclk);
        pulse_vec <= 16'h0000;
      end
    join
    rd_chk(`ICS_OFF_CAUSE_A, 32'h0000_0004, "set beats clear");
    clr_all();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_events();
    t_group();
    t_timing();
    t_clear();
    results();
  end
endmodule // testbench

// [src/ics_cfg.svh]
// constants of the interrupt cause block: register offsets, field positions,
// reset values and masks.
// assumes it is included by its bare name before the package and the design.
`ifndef ICS_CFG_SVH
`define ICS_CFG_SVH

// apb address width and register offsets (byte addresses, one word each)
`define ICS_ADDR_W 12
`define ICS_OFF_CAUSE_A 12'h000
`define ICS_OFF_CAUSE_B 12'h004
`define ICS_OFF_CAUSE_C 12'h008
`define ICS_OFF_ENABLE_A 12'h00C
`define ICS_OFF_ENABLE_B 12'h010
`define ICS_OFF_ENABLE_C 12'h014
`define ICS_OFF_TIMING_A 12'h018
`define ICS_OFF_TIMING_B 12'h01C
`define ICS_OFF_WATCH 12'h020

// cause bit positions, shared by all three cause registers
`define ICS_BIT_TIME_MATCH 0
`define ICS_BIT_BLOCK_UPDATE 1
`define ICS_BIT_MAIL_IN 2
`define ICS_BIT_MAIL_OUT_DONE 3
`define ICS_BIT_GROUP_MISMATCH 4
`define ICS_BIT_GROUP_EXCESS 5
`define ICS_BIT_RESIZE_DONE 6
`define ICS_BIT_NET_HALT 7
`define ICS_BIT_RUN_ENTRY 8
`define ICS_BIT_MEMBERSHIP_CHANGE 9
`define ICS_BIT_LINK_GOOD 10
`define ICS_BIT_LINK_BAD 11
`define ICS_BIT_BREAK_PACKET 12
`define ICS_BIT_RESIZE_CLASH 13
`define ICS_BIT_ECHO_REQUEST 14
`define ICS_BIT_JAM_SEEN 15

// timing match field positions: alarm time low, renewal check time high
`define ICS_TIME_ALARM_LSB 0
`define ICS_TIME_RENEW_LSB 8
`define ICS_TIME_W 7

// reset values, writable masks and the freeze cause mask
`define ICS_RST_CAUSE 16'h0000
`define ICS_RST_ENABLE 16'h0000
`define ICS_RST_TIMING 16'h0000
`define ICS_PIN_C_MASK 16'hFFFC
`define ICS_TIMING_MASK 16'h7F7F
`define ICS_FREEZE_MASK 16'h0E00

`endif

// [src/ics_irq_cause.sv]
// interrupt cause latching for three active-low interrupt pins, with apb
// access to cause, enable, timing match and block watch registers.
// assumes event inputs are one-cycle pulses synchronous to pclk, and that
// station_time is valid whenever station_time_stb is high.
//
// Chosen here: the register offsets and the APB interface to the registers.
`include "ics_cfg.svh"

module ics_irq_cause #(
  parameter int MEMBER_W = 64, // width of the member flag sets
  parameter int NBLK = 16 // memory blocks under renewal watch, at most 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ICS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [`ICS_TIME_W-1:0] station_time,
  input wire logic station_time_stb,
  input wire logic [NBLK-1:0] block_dirty,
  input wire logic mail_in_done,
  input wire logic mail_out_done,
  input wire logic group_cmp_stb,
  input wire logic [MEMBER_W-1:0] expected_group_set,
  input wire logic [MEMBER_W-1:0] present_member_set,
  input wire logic resize_done,
  input wire logic net_halt,
  input wire logic run_phase,
  input wire logic link_good_stb,
  input wire logic link_bad_stb,
  input wire logic break_rx,
  input wire logic resize_clash,
  input wire logic echo_rx,
  input wire logic jam_rx,
  output logic irq_pin_a_n,
  output logic irq_pin_b_n,
  output logic irq_pin_c_n,
  output logic status_freeze
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  // width of a population count of the present member set
  localparam int CW = $clog2(MEMBER_W + 1);

  // the whole state of the block in one word
  typedef struct packed {
    ics_pkg::ics_phase_e phase; // apb answer phase
    logic pready; // apb ready flop
    logic pslverr; // apb error flop
    logic [31:0] prdata; // apb read data flop
    logic [2:0][15:0] cause; // sticky cause flags, pins a to c
    logic [2:0][15:0] enable; // per pin cause enables
    logic [1:0][15:0] timing; // alarm and renewal times, pins a and b
    logic [NBLK-1:0] watch; // block watch select
    logic run_seen; // run phase level last cycle
    logic [CW-1:0] member_cnt; // member count last cycle
    logic [2:0] pin_n; // pin levels, active low
    logic freeze; // freeze request to link status logic
  } ics_state_s;

  ics_state_s state_reg; // registered state
  ics_state_s state_next; // next state

  ////////////////////////////////////////////////////////////////////////////
  // event detection

  logic [15:0] common_set; // causes shared by all pins
  logic [2:0][15:0] set_vec; // causes per pin
  logic [1:0] time_hit; // alarm time reached, pins a and b
  logic [1:0] renew_hit; // watched block changed at check time
  logic watched_dirty; // some watched block has new data
  logic [CW-1:0] member_now; // present member count
  logic member_evt; // count rose or fell
  logic run_evt; // run phase entered
  logic set_differ; // expected and present sets differ
  logic set_greater; // expected set greater than present

  // a watch register wider than the block count is simply cut
  assign watched_dirty = |(block_dirty & state_reg.watch);
  assign member_now = CW'($countones(present_member_set));
  assign member_evt = member_now != state_reg.member_cnt;
  assign run_evt = run_phase && !state_reg.run_seen;
  assign set_differ = expected_group_set != present_member_set;
  assign set_greater = expected_group_set > present_member_set;

  // shared causes, one per bit position
  always_comb begin
    common_set = 16'h0000;
    common_set[`ICS_BIT_MAIL_IN] = mail_in_done;
    common_set[`ICS_BIT_MAIL_OUT_DONE] = mail_out_done;
    common_set[`ICS_BIT_GROUP_MISMATCH] = group_cmp_stb && set_differ;
    common_set[`ICS_BIT_GROUP_EXCESS] = group_cmp_stb && set_greater;
    common_set[`ICS_BIT_RESIZE_DONE] = resize_done;
    common_set[`ICS_BIT_NET_HALT] = net_halt;
    common_set[`ICS_BIT_RUN_ENTRY] = run_evt;
    common_set[`ICS_BIT_MEMBERSHIP_CHANGE] = member_evt;
    common_set[`ICS_BIT_LINK_GOOD] = link_good_stb;
    common_set[`ICS_BIT_LINK_BAD] = link_bad_stb;
    common_set[`ICS_BIT_BREAK_PACKET] = break_rx;
    common_set[`ICS_BIT_RESIZE_CLASH] = resize_clash;
    common_set[`ICS_BIT_ECHO_REQUEST] = echo_rx;
    common_set[`ICS_BIT_JAM_SEEN] = jam_rx;
  end

  // per pin cause vectors; only pins a and b have timing matches
  for (genvar p = 0; p < 3; p++) begin : g_pin
    if (p < 2) begin : g_timed
      // a time beyond the last station never matches, so no cause fires
      assign time_hit[p] = station_time_stb &&
        (station_time == state_reg.timing[p][`ICS_TIME_ALARM_LSB +: `ICS_TIME_W]);
      assign renew_hit[p] = station_time_stb && watched_dirty &&
        (station_time == state_reg.timing[p][`ICS_TIME_RENEW_LSB +: `ICS_TIME_W]);
      // bit 1 is the block update cause, bit 0 the time match cause
      assign set_vec[p] = {common_set[15:2], renew_hit[p], time_hit[p]};
    end else begin : g_plain
      assign set_vec[p] = common_set & `ICS_PIN_C_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode

  logic setup_ph; // setup cycle of a transfer
  logic access_ok; // access phase completing this edge
  logic wr_now; // write takes effect this edge
  logic addr_hit; // address maps onto a register
  logic [31:0] rd_word; // read mux

  assign setup_ph = psel && !penable;
  assign access_ok = psel && penable && state_reg.pready;
  assign wr_now = access_ok && pwrite && !state_reg.pslverr;

  // read mux, narrower registers sit in the low bits
  always_comb begin
    rd_word = 32'h0000_0000;
    addr_hit = 1'b1;
    case (paddr)
      `ICS_OFF_CAUSE_A: rd_word[15:0] = state_reg.cause[0];
      `ICS_OFF_CAUSE_B: rd_word[15:0] = state_reg.cause[1];
      `ICS_OFF_CAUSE_C: rd_word[15:0] = state_reg.cause[2];
      `ICS_OFF_ENABLE_A: rd_word[15:0] = state_reg.enable[0];
      `ICS_OFF_ENABLE_B: rd_word[15:0] = state_reg.enable[1];
      `ICS_OFF_ENABLE_C: rd_word[15:0] = state_reg.enable[2];
      `ICS_OFF_TIMING_A: rd_word[15:0] = state_reg.timing[0];
      `ICS_OFF_TIMING_B: rd_word[15:0] = state_reg.timing[1];
      `ICS_OFF_WATCH: rd_word[NBLK-1:0] = state_reg.watch;
      default: addr_hit = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    logic [2:0][15:0] clr; // write-one-to-clear masks
    logic [15:0] en_w; // enable write data
    clr = '0;
    en_w = pwdata[15:0];
    state_next = state_reg;
    state_next.run_seen = run_phase;
    state_next.member_cnt = member_now;

    // apb phase: answer with zero wait states in the first access cycle
    case (state_reg.phase)
      ics_pkg::ICS_PH_IDLE: begin
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
        if (setup_ph) begin
          state_next.phase = ics_pkg::ICS_PH_ANSWER;
          state_next.pready = 1'b1;
          state_next.pslverr = !addr_hit;
          state_next.prdata = pwrite ? 32'h0000_0000 : rd_word;
        end
      end
      ics_pkg::ICS_PH_ANSWER: begin
        // the master holds the request until this edge
        state_next.phase = ics_pkg::ICS_PH_IDLE;
        state_next.pready = 1'b0;
        state_next.pslverr = 1'b0;
      end
      default: begin
        state_next.phase = ics_pkg::ICS_PH_IDLE;
        state_next.pready = 1'b0;
      end
    endcase

    // register writes, unmapped addresses have no effect
    if (wr_now) begin
      case (paddr)
        `ICS_OFF_CAUSE_A: clr[0] = pwdata[15:0];
        `ICS_OFF_CAUSE_B: clr[1] = pwdata[15:0];
        `ICS_OFF_CAUSE_C: clr[2] = pwdata[15:0];
        `ICS_OFF_ENABLE_A: begin
          // renewal may be enabled on one pin only
          if (state_reg.enable[1][`ICS_BIT_BLOCK_UPDATE]) begin
            en_w[`ICS_BIT_BLOCK_UPDATE] = state_reg.enable[0][`ICS_BIT_BLOCK_UPDATE];
          end
          state_next.enable[0] = en_w;
        end
        `ICS_OFF_ENABLE_B: begin
          if (state_reg.enable[0][`ICS_BIT_BLOCK_UPDATE]) begin
            en_w[`ICS_BIT_BLOCK_UPDATE] = state_reg.enable[1][`ICS_BIT_BLOCK_UPDATE];
          end
          state_next.enable[1] = en_w;
        end
        `ICS_OFF_ENABLE_C: state_next.enable[2] = en_w & `ICS_PIN_C_MASK;
        `ICS_OFF_TIMING_A: state_next.timing[0] = pwdata[15:0] & `ICS_TIMING_MASK;
        `ICS_OFF_TIMING_B: state_next.timing[1] = pwdata[15:0] & `ICS_TIMING_MASK;
        `ICS_OFF_WATCH: state_next.watch = pwdata[NBLK-1:0];
        default: ;
      endcase
    end

    // sticky flags: set wins over a clear in the same cycle
    for (int p = 0; p < 3; p++) begin
      state_next.cause[p] = (state_reg.cause[p] & ~clr[p]) | set_vec[p];
    end

    // pins follow the flags in the same edge; disabled causes are held but
    // silent, so a pin can read high while its register is non-zero
    for (int p = 0; p < 3; p++) begin
      state_next.pin_n[p] = ~|(state_next.cause[p] & state_next.enable[p]);
    end

    // link status freezes while a membership or link interrupt is asserted
    state_next.freeze = 1'b0;
    for (int p = 0; p < 3; p++) begin
      if (|(state_next.cause[p] & state_next.enable[p] & `ICS_FREEZE_MASK)) begin
        state_next.freeze = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg.phase <= ics_pkg::ICS_PH_IDLE;
      state_reg.pready <= 1'b0;
      state_reg.pslverr <= 1'b0;
      state_reg.prdata <= 32'h0000_0000;
      state_reg.cause <= {3{`ICS_RST_CAUSE}};
      state_reg.enable <= {3{`ICS_RST_ENABLE}};
      state_reg.timing <= {2{`ICS_RST_TIMING}};
      state_reg.watch <= '0;
      state_reg.run_seen <= 1'b0;
      state_reg.member_cnt <= '0;
      state_reg.pin_n <= 3'b111;
      state_reg.freeze <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, straight from flops

  assign pready = state_reg.pready;
  assign prdata = state_reg.prdata;
  assign pslverr = state_reg.pslverr;
  assign irq_pin_a_n = state_reg.pin_n[0];
  assign irq_pin_b_n = state_reg.pin_n[1];
  assign irq_pin_c_n = state_reg.pin_n[2];
  assign status_freeze = state_reg.freeze;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // a write that clears cause a bit 2
  sequence s_clear_mail_a;
    wr_now && paddr == `ICS_OFF_CAUSE_A && pwdata[`ICS_BIT_MAIL_IN];
  endsequence

  // run phase entered after being absent
  sequence s_run_rise;
    !run_phase ##1 run_phase;
  endsequence

  // mail event seen while its cause is enabled on pin a
  sequence s_mail_enabled;
    mail_in_done && state_reg.enable[0][`ICS_BIT_MAIL_IN];
  endsequence

  AST_MAIL_SET: assert property (mail_in_done |=> state_reg.cause[1][`ICS_BIT_MAIL_IN])
    else $error("mail event did not set cause b");

  AST_PIN_HIGH: assert property (state_reg.cause[0] == 16'h0000 |-> irq_pin_a_n)
    else $error("pin a low with empty cause register");

  AST_W1C: assert property ((s_clear_mail_a and !mail_in_done) |=> !state_reg.cause[0][`ICS_BIT_MAIL_IN])
    else $error("write one did not clear flag");

  AST_ZERO_IGNORED: assert property (wr_now && paddr == `ICS_OFF_CAUSE_A && !pwdata[`ICS_BIT_MAIL_IN]
      && state_reg.cause[0][`ICS_BIT_MAIL_IN] |=> state_reg.cause[0][`ICS_BIT_MAIL_IN])
    else $error("write zero changed a flag");

  AST_ALARM: assert property (time_hit[1] |=> state_reg.cause[1][`ICS_BIT_TIME_MATCH])
    else $error("alarm match did not set flag");

  AST_RENEW: assert property (station_time_stb && watched_dirty && station_time ==
      state_reg.timing[0][`ICS_TIME_RENEW_LSB +: `ICS_TIME_W] |=> state_reg.cause[0][1])
    else $error("renewal check did not set flag");

  // pin b renewal follows its own check time
  AST_RENEW_B: assert property (renew_hit[1] |=> state_reg.cause[1][`ICS_BIT_BLOCK_UPDATE])
    else $error("pin b renewal did not set flag");

  AST_GROUP: assert property (group_cmp_stb && set_greater |=> state_reg.cause[2][5:4] == 2'b11)
    else $error("greater group set did not set both bits");

  AST_RUN: assert property (s_run_rise |=> state_reg.cause[0][`ICS_BIT_RUN_ENTRY])
    else $error("run entry not flagged");

  AST_MEMBER: assert property ($changed(member_now) |=> state_reg.cause[2][`ICS_BIT_MEMBERSHIP_CHANGE])
    else $error("member count change not flagged");

  AST_PIN_C_LOW_BITS: assert property (state_reg.cause[2][1:0] == 2'b00)
    else $error("pin c bits 0 and 1 not zero");

  // pin c is released once its register is empty
  AST_PIN_C_HIGH: assert property (state_reg.cause[2] == 16'h0000 |-> irq_pin_c_n)
    else $error("pin c low with empty cause register");

  AST_PIN_LOW: assert property (s_mail_enabled |=> !irq_pin_a_n)
    else $error("enabled cause did not drive pin a low");

  AST_RENEW_ONE_PIN: assert property (!(state_reg.enable[0][1] && state_reg.enable[1][1]))
    else $error("renewal enabled on both pins");

  AST_FREEZE: assert property (link_bad_stb && state_reg.enable[1][`ICS_BIT_LINK_BAD]
      |=> status_freeze [*2] or (status_freeze ##1 $fell(state_reg.cause[1][11])))
    else $error("link status not frozen");

  AST_SET_WINS: assert property ((s_clear_mail_a and mail_in_done) |=> state_reg.cause[0][2])
    else $error("clear beat a new event");

  AST_APB_ANSWER: assert property (setup_ph |=> pready ##1 !pready)
    else $error("apb answer not one cycle after setup");

endmodule // ics_irq_cause

// [src/ics_pkg.sv]
// types of the interrupt cause block.
// assumes ics_cfg.svh is available on the include path.
package ics_pkg;

  // one cause, enable or timing word
  typedef logic [15:0] ics_word_t;

  // apb slave phase: idle, or answering an access phase
  typedef enum logic [0:0] {
    ICS_PH_IDLE = 1'b0,
    ICS_PH_ANSWER = 1'b1
  } ics_phase_e;

endpackage
